/* File: verilog/tlr_cfg.svh */
`ifndef TLR_CFG_SVH
`define TLR_CFG_SVH
// Register byte offsets
`define TLR_OFF_CTRL 6'h00
`define TLR_OFF_LDOK 6'h04
`define TLR_OFF_STAT 6'h08
`define TLR_OFF_G0TV 6'h0c
`define TLR_OFF_G1TV 6'h10
`define TLR_OFF_LIST 6'h14
`define TLR_OFF_IDX 6'h18
`define TLR_OFF_CNTR 6'h1c
`define TLR_OFF_MADR 6'h20
`define TLR_OFF_MDAT 6'h24
// Control field positions
`define TLR_CTRL_G0EN 0
`define TLR_CTRL_G1EN 1
`define TLR_CTRL_FRZ 2
`define TLR_CTRL_SWRL 3
// Status field positions
`define TLR_STAT_ROIF 0
`define TLR_STAT_D0 1
`define TLR_STAT_D1 2
// Reset values and markers
`define TLR_RST_CTRL 4'h0
`define TLR_EOL 16'h0000
`define TLR_LIST_LEN 6'd32
`endif

/* File: verilog/tlr_pkg.sv */
// Purpose: Types shared by the trigger list reload unit
// Assumes: Nothing
// Notes: Constants live in tlr_cfg.svh
package tlr_pkg;
  typedef enum logic [1:0] {GS_IDLE, GS_FETCH, GS_WAIT, GS_DONE} tlr_gstate_t;
  typedef struct packed {
    logic [7:0] l0_idx;
    logic [7:0] l1_idx;
  } tlr_idx_t;
  typedef struct packed {
    logic reload;
    logic async_q;
  } tlr_rl_t;
endpackage

/* File: verilog/tlr_mem.sv */
// Purpose: Trigger list memory, one CPU write port, one registered read port
// Assumes: Single clock
// Notes: Read data appear one cycle after the address
module tlr_mem
  import tlr_pkg::*;
#(
  parameter int AW = 8,
  parameter int DW = 16
)
(
  input wire logic i_sys_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge i_sys_clk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

/* File: verilog/tlr_top.sv */
// Purpose: Two trigger generators fed from double-buffered lists in memory
// Assumes: Avalon-MM slave, one clock, mode inputs from the system
// Notes: Shared list memory, generators fetch in turn; read latency one cycle
`include "tlr_cfg.svh"
module tlr_top
  import tlr_pkg::*;
#(
  parameter int AW = 8
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_freeze_mode,
  input wire logic i_stop_mode,
  input wire logic i_reload,
  input wire logic i_async_reload_qualifier,
  output logic o_trigger0,
  output logic o_trigger1,
  output logic o_global_load_ok
);
  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  logic [3:0] ctrl_reg;
  logic global_load_ok_reg;
  logic reload_overrun_flag_reg;
  logic [1:0] gen_done_flag_reg;
  logic [1:0] gen_active_list_reg;
  tlr_idx_t idx_reg [2];
  logic [15:0] cnt_reg;
  logic [15:0] tv_reg [2];
  logic [5:0] nfetch_reg [2];
  logic [AW-1:0] ptr_reg [2];
  tlr_gstate_t gst_reg [2];
  logic [AW-1:0] madr_reg;
  logic [1:0] rl_sync_reg;
  logic [1:0] frz_sync_reg;
  logic [1:0] stp_sync_reg;
  logic [1:0] aq_sync_reg;
  logic rl_prev_reg;
  logic ack_reg;
  logic fsel_reg;
  logic fpend_reg;
  logic fvld_reg;
  logic [1:0] trig_reg;

  tlr_rl_t rl_in;
  logic run;
  logic rl_evt;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic [AW-1:0] raddr;
  logic [15:0] rdata_mem;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
    hit = (a == off);
  endfunction

  // Writes land at the edge where the master sees waitrequest low
  assign wr = i_avs_write && !o_avs_waitrequest;
  assign rd = i_avs_read && !ack_reg;
  assign rl_in = '{reload: rl_sync_reg[1], async_q: aq_sync_reg[1]};

  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rl_sync_reg <= 2'h0;
      frz_sync_reg <= 2'h0;
      stp_sync_reg <= 2'h0;
      aq_sync_reg <= 2'h0;
      rl_prev_reg <= 1'b0;
    end
    else
    begin
      rl_sync_reg <= {rl_sync_reg[0], i_reload};
      frz_sync_reg <= {frz_sync_reg[0], i_freeze_mode};
      stp_sync_reg <= {stp_sync_reg[0], i_stop_mode};
      // Qualifier travels beside the reload pin so both stay aligned
      aq_sync_reg <= {aq_sync_reg[0], i_async_reload_qualifier};
      rl_prev_reg <= rl_sync_reg[1];
    end
  end

  // Reload is either an edge of the pin or a software request; the async
  // qualifier path does the same thing, from the same pin edge gated by the qualifier
  assign rl_evt = (rl_in.reload && !rl_prev_reg) || (rl_in.reload && rl_in.async_q)
                  && !rl_prev_reg
                  || (wr && hit(i_avs_address, `TLR_OFF_CTRL)
                      && i_avs_writedata[`TLR_CTRL_SWRL]);

  // Run and wait need no gating; only freeze with halt and stop do
  assign run = !stp_sync_reg[1] && !(frz_sync_reg[1] && ctrl_reg[`TLR_CTRL_FRZ]);

  // -----------------------------------------------------------------
  // Avalon slave: one wait cycle, then acknowledge
  // -----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ack_reg <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0;
    end
    else
    begin
      ack_reg <= (i_avs_read || i_avs_write) && !ack_reg;
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !ack_reg);
      if (rd)
      begin
        o_avs_readdata <= {16'h0, rdata};
      end
    end
  end

  always_comb
  begin
    rdata = 16'h0;
    unique case (i_avs_address)
      `TLR_OFF_CTRL: rdata = {12'h0, 1'b0, ctrl_reg[2:0]};
      `TLR_OFF_LDOK: rdata = {15'h0, global_load_ok_reg};
      `TLR_OFF_STAT: rdata = {13'h0, gen_done_flag_reg, reload_overrun_flag_reg};
      `TLR_OFF_G0TV: rdata = tv_reg[0];
      `TLR_OFF_G1TV: rdata = tv_reg[1];
      `TLR_OFF_LIST: rdata = {14'h0, gen_active_list_reg};
      `TLR_OFF_IDX: rdata = {idx_reg[1].l0_idx[3:0], idx_reg[1].l1_idx[3:0],
                             idx_reg[0].l0_idx[3:0], idx_reg[0].l1_idx[3:0]};
      `TLR_OFF_CNTR: rdata = cnt_reg;
      `TLR_OFF_MADR: rdata = {{(16-AW){1'b0}}, madr_reg};
      default: rdata = 16'h0;
    endcase
  end

  // -----------------------------------------------------------------
  // Configuration; kept through stop mode
  // -----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl_reg <= `TLR_RST_CTRL;
      madr_reg <= '0;
      idx_reg[0] <= '0;
      idx_reg[1] <= '0;
    end
    else if (wr && i_avs_byteenable[0])
    begin
      if (hit(i_avs_address, `TLR_OFF_CTRL))
      begin
        ctrl_reg <= {1'b0, i_avs_writedata[2:0]};
      end
      if (hit(i_avs_address, `TLR_OFF_MADR))
      begin
        madr_reg <= i_avs_writedata[AW-1:0];
      end
      if (hit(i_avs_address, `TLR_OFF_IDX) && i_avs_byteenable[1])
      begin
        // Equal start indices are accepted unchanged
        idx_reg[0] <= '{l0_idx: {4'h0, i_avs_writedata[7:4]},
                        l1_idx: {4'h0, i_avs_writedata[3:0]}};
        idx_reg[1] <= '{l0_idx: {4'h0, i_avs_writedata[15:12]},
                        l1_idx: {4'h0, i_avs_writedata[11:8]}};
      end
    end
  end

  // -----------------------------------------------------------------
  // Load-ok and overrun; reload clear beats software set
  // -----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      global_load_ok_reg <= 1'b0;
      o_global_load_ok <= 1'b0;
    end
    else
    begin
      if (rl_evt)
      begin
        global_load_ok_reg <= 1'b0;
      end
      else if (wr && hit(i_avs_address, `TLR_OFF_LDOK) && i_avs_writedata[0])
      begin
        global_load_ok_reg <= 1'b1;
      end
      o_global_load_ok <= global_load_ok_reg;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      reload_overrun_flag_reg <= 1'b0;
    end
    else if (rl_evt && !global_load_ok_reg)
    begin
      reload_overrun_flag_reg <= 1'b1;
    end
    else if (wr && hit(i_avs_address, `TLR_OFF_STAT) && i_avs_writedata[`TLR_STAT_ROIF])
    begin
      reload_overrun_flag_reg <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Time base counter, restarted by every reload
  // -----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_reg <= 16'h0;
    end
    else if (rl_evt)
    begin
      cnt_reg <= 16'h0;
    end
    else if (run)
    begin
      cnt_reg <= cnt_reg + 16'h1;
    end
  end

  // -----------------------------------------------------------------
  // List memory; CPU writes at the address pointer, generators read
  // -----------------------------------------------------------------
  assign raddr = ptr_reg[fsel_reg];

  tlr_mem #(.AW(AW), .DW(16)) u_mem (
    .i_sys_clk(i_sys_clk),
    .i_we(wr && hit(i_avs_address, `TLR_OFF_MDAT)),
    .i_waddr(madr_reg),
    .i_wdata(i_avs_writedata[15:0]),
    .i_raddr(raddr),
    .o_rdata(rdata_mem)
  );

  // Fetch arbiter: one outstanding read, generators alternate
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      fsel_reg <= 1'b0;
      fpend_reg <= 1'b0;
      fvld_reg <= 1'b0;
    end
    else if (fpend_reg)
    begin
      // Address goes into memory now, data come out next edge
      fpend_reg <= 1'b0;
      fvld_reg <= 1'b1;
    end
    else if (fvld_reg)
    begin
      // Let the generator leave fetch before the next pick
      fvld_reg <= 1'b0;
    end
    else if (gst_reg[~fsel_reg] == GS_FETCH)
    begin
      fsel_reg <= ~fsel_reg;
      fpend_reg <= 1'b1;
    end
    else if (gst_reg[fsel_reg] == GS_FETCH)
    begin
      fpend_reg <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Trigger generators
  // -----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++)
  begin : gen_tg
    logic en;
    logic got;
    logic nxt_list;
    assign en = ctrl_reg[g];
    assign got = fvld_reg && (fsel_reg == 1'(g)) && gst_reg[g] == GS_FETCH;
    // Swap only on accepted reloads; a single shared list still toggles
    assign nxt_list = global_load_ok_reg ? ~gen_active_list_reg[g]
                                         : gen_active_list_reg[g];

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        gen_active_list_reg[g] <= 1'b0;
      end
      else if (en && rl_evt)
      begin
        gen_active_list_reg[g] <= nxt_list;
      end
      else if (!en && wr && hit(i_avs_address, `TLR_OFF_LIST))
      begin
        gen_active_list_reg[g] <= i_avs_writedata[g];
      end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        gst_reg[g] <= GS_IDLE;
        ptr_reg[g] <= '0;
        tv_reg[g] <= 16'h0;
        nfetch_reg[g] <= 6'h0;
        gen_done_flag_reg[g] <= 1'b0;
        trig_reg[g] <= 1'b0;
      end
      else
      begin
        trig_reg[g] <= 1'b0;
        if (wr && hit(i_avs_address, `TLR_OFF_STAT) && i_avs_writedata[g+1])
        begin
          gen_done_flag_reg[g] <= 1'b0;
        end
        if (!en)
        begin
          gst_reg[g] <= GS_IDLE;
        end
        else if (rl_evt)
        begin
          // Fetch first value of the list now in use
          ptr_reg[g] <= AW'(nxt_list ? idx_reg[g].l1_idx : idx_reg[g].l0_idx);
          nfetch_reg[g] <= 6'h0;
          gst_reg[g] <= GS_FETCH;
        end
        else
        begin
          unique case (gst_reg[g])
            GS_IDLE:
            begin
              gst_reg[g] <= GS_IDLE;
            end
            GS_FETCH:
            begin
              if (got)
              begin
                tv_reg[g] <= rdata_mem;
                ptr_reg[g] <= ptr_reg[g] + AW'(1);
                nfetch_reg[g] <= nfetch_reg[g] + 6'h1;
                if (rdata_mem == `TLR_EOL)
                begin
                  gen_done_flag_reg[g] <= 1'b1;
                  gst_reg[g] <= GS_DONE;
                end
                else
                begin
                  gst_reg[g] <= GS_WAIT;
                end
              end
            end
            GS_WAIT:
            begin
              if (run && cnt_reg == tv_reg[g])
              begin
                trig_reg[g] <= 1'b1;
                // Value of the last trigger stays visible
                gst_reg[g] <= (nfetch_reg[g] == `TLR_LIST_LEN) ? GS_DONE : GS_FETCH;
                if (nfetch_reg[g] == `TLR_LIST_LEN)
                begin
                  gen_done_flag_reg[g] <= 1'b1;
                end
              end
            end
            GS_DONE:
            begin
              gst_reg[g] <= GS_DONE;
            end
          endcase
        end
      end
    end
  end

  assign o_trigger0 = trig_reg[0];
  assign o_trigger1 = trig_reg[1];
endmodule

/* File: testbench/tlr_top_sva.sv */
// Purpose: Port-level timing checks on the trigger list reload unit
// Assumes: One clock, asynchronous active-low reset
// Notes: Reload and mode inputs pass a short synchroniser, so bounds allow a few cycles
`include "tlr_cfg.svh"
module tlr_top_sva (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic i_stop_mode,
  input wire logic i_reload,
  input wire logic i_async_reload_qualifier,
  input wire logic o_trigger0,
  input wire logic o_trigger1,
  input wire logic o_global_load_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ldok_wr;
  assign ldok_wr = i_avs_write && (i_avs_address == `TLR_OFF_LDOK) && !o_avs_waitrequest;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  trig0_pulse_a: assert property (o_trigger0 |=> !o_trigger0)
    else $error("trigger 0 longer than one cycle");
  trig1_pulse_a: assert property (o_trigger1 |=> !o_trigger1)
    else $error("trigger 1 longer than one cycle");
  stop_quiet_a: assert property (i_stop_mode [*5] |-> !o_trigger0 && !o_trigger1)
    else $error("trigger during stop");
  reload_clear_a: assert property ($rose(i_reload) |-> ##[1:8] !o_global_load_ok)
    else $error("load ok survives reload");
  async_clear_a: assert property ($rose(i_reload) && i_async_reload_qualifier
    |-> ##[1:8] !o_global_load_ok)
    else $error("load ok survives async reload");
  ok_cause_a: assert property ($rose(o_global_load_ok)
    |-> $past(ldok_wr, 1) || $past(ldok_wr, 2) || $past(ldok_wr, 3))
    else $error("load ok rose without a write");
  rd_answer_a: assert property (i_avs_read && o_avs_waitrequest
    |-> ##[1:3] !o_avs_waitrequest)
    else $error("read not answered");
  wr_answer_a: assert property (i_avs_write && o_avs_waitrequest
    |-> ##[1:3] !o_avs_waitrequest)
    else $error("write not answered");
  ack_once_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("answer held over two cycles");
endmodule
bind tlr_top tlr_top_sva u_tlr_top_sva (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .i_stop_mode(i_stop_mode), .i_reload(i_reload),
  .i_async_reload_qualifier(i_async_reload_qualifier), .o_trigger0(o_trigger0),
  .o_trigger1(o_trigger1), .o_global_load_ok(o_global_load_ok));

/* File: testbench/tlr_far_end.sv */
// Purpose: Reload source and trigger consumer beside the unit
// Assumes: Reload held several cycles so the unit's synchroniser sees it
// Notes: Hold time chosen by the caller gives prompt and slow sources
module tlr_far_end (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_trigger0,
  input wire logic i_trigger1,
  output logic o_reload,
  output logic o_async_q,
  output logic [15:0] o_count0,
  output logic [15:0] o_count1
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_reload = 1'b0;
    o_async_q = 1'b0;
  end
  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_count0 <= 16'h0000;
      o_count1 <= 16'h0000;
    end
    else
    begin
      o_count0 <= o_count0 + {15'h0000, i_trigger0};
      o_count1 <= o_count1 + {15'h0000, i_trigger1};
    end
  end
  task automatic fire(input logic async_q, input int hold);
    @(posedge i_sys_clk);
    o_reload <= 1'b1;
    o_async_q <= async_q;
    repeat (hold) @(posedge i_sys_clk);
    o_reload <= 1'b0;
    o_async_q <= 1'b0;
  endtask
endmodule

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the trigger list reload unit
// Assumes: Avalon-MM master, one 50 MHz clock
// Notes: All lists share start index 0, so one physical list serves both pointers
`include "tlr_cfg.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, rd, wr, wreq, frz, stop, rl, aq, t0, t1, ok_out, ok;
  logic [5:0] addr;
  logic [31:0] wdata, rdata, d, v;
  logic [15:0] lfsr, c0, c1, c;
  logic [1:0] lst;
  int err_count, checked;
  tlr_top u_tlr_top (.i_sys_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_freeze_mode(frz),
    .i_stop_mode(stop), .i_reload(rl), .i_async_reload_qualifier(aq),
    .o_trigger0(t0), .o_trigger1(t1), .o_global_load_ok(ok_out));
  tlr_far_end u_tlr_far_end (.i_sys_clk(clk), .i_rst_n(rst_n), .i_trigger0(t0),
    .i_trigger1(t1), .o_reload(rl), .o_async_q(aq), .o_count0(c0), .o_count1(c1));
  always #10 clk = ~clk;
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Accepted reload flips both list bits, refused one leaves them
  function automatic logic [1:0] exp_list(input logic [1:0] p, input logic k);
    return k ? ~p : p;
  endfunction
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Holds the request until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= wd;
    if (w)
      wr <= 1'b1;
    else
      rd <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    d = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (wreq !== 1'b0)
    begin
      err_count++;
      close_out();
    end
  endtask
  initial
  begin
    clk = 0; rst_n = 0; rd = 0; wr = 0; addr = 0; wdata = 0; frz = 0; stop = 0;
    lfsr = 16'h0032;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, `TLR_OFF_CTRL, 0); `CHK(d, 32'h0)
    bus(0, `TLR_OFF_LIST, 0); `CHK(d[1:0], 2'b00)
    bus(0, 6'h3c, 0); `CHK(d, 32'h0)
    bus(0, `TLR_OFF_G0TV, 0); v = d;
    bus(1, `TLR_OFF_G0TV, {16'h0000, lfsr});
    bus(0, `TLR_OFF_G0TV, 0); `CHK(d, v)
    $display("test registers done");
    for (int i = 0; i <= 32; i++)
    begin
      bus(1, `TLR_OFF_MADR, i);
      bus(1, `TLR_OFF_MDAT, (i == 32) ? {16'h0000, `TLR_EOL} : 20 * (i + 1));
    end
    bus(1, `TLR_OFF_IDX, 0);
    bus(1, `TLR_OFF_LIST, 3); bus(0, `TLR_OFF_LIST, 0); `CHK(d[1:0], 2'b11)
    bus(1, `TLR_OFF_CTRL, 2); bus(1, `TLR_OFF_LIST, 0);
    bus(0, `TLR_OFF_LIST, 0); `CHK(d[1:0], 2'b10)
    bus(1, `TLR_OFF_CTRL, 3);
    lst = 2'b10;
    $display("test list setup done");
    for (int k = 0; k < 6; k++)
    begin
      lfsr = nxt(lfsr);
      ok = lfsr[0] | (k == 0);
      if (ok)
        bus(1, `TLR_OFF_LDOK, 1);
      repeat (2) @(posedge clk);
      `CHK(ok_out, ok)
      u_tlr_far_end.fire(k[0], lfsr[1] ? 4 : 12);
      repeat (8) @(posedge clk);
      `CHK(ok_out, 1'b0)
      lst = exp_list(lst, ok);
      bus(0, `TLR_OFF_LIST, 0); `CHK(d[1:0], lst)
      bus(0, `TLR_OFF_STAT, 0); `CHK(d[0], !ok)
      bus(1, `TLR_OFF_STAT, 1);
      repeat (700) @(posedge clk);
    end
    // Every reload runs the whole shared list, one trigger per entry
    `CHK(c0, 16'(6 * `TLR_LIST_LEN))
    `CHK(c1, 16'(6 * `TLR_LIST_LEN))
    bus(0, `TLR_OFF_G0TV, 0); `CHK(d[15:0], 16'(20 * `TLR_LIST_LEN))
    bus(0, `TLR_OFF_STAT, 0); `CHK(d[2:1], 2'b11)
    $display("test reload done");
    // Stop, freeze with halt, freeze without halt
    for (int m = 0; m < 3; m++)
    begin
      bus(1, `TLR_OFF_CTRL, (m == 1) ? 7 : 3);
      bus(1, `TLR_OFF_LDOK, 1);
      u_tlr_far_end.fire(1'b0, 4);
      frz <= (m != 0);
      stop <= (m == 0);
      repeat (4) @(posedge clk);
      c = c0;
      repeat (300) @(posedge clk);
      `CHK(c0 == c, m != 2)
      frz <= 1'b0;
      stop <= 1'b0;
      bus(0, `TLR_OFF_CTRL, 0); `CHK(d[2:0], (m == 1) ? 3'b111 : 3'b011)
      repeat (700) @(posedge clk);
      `CHK(c0 != c, 1'b1)
    end
    $display("test modes done");
    // Short list ended by the marker, started by a software reload
    bus(1, `TLR_OFF_STAT, 6);
    bus(1, `TLR_OFF_MADR, 2);
    bus(1, `TLR_OFF_MDAT, {16'h0000, `TLR_EOL});
    bus(1, `TLR_OFF_LDOK, 1);
    c = c0;
    bus(1, `TLR_OFF_CTRL, 32'hb);
    repeat (200) @(posedge clk);
    `CHK(c0, c + 16'h2)
    bus(0, `TLR_OFF_G0TV, 0); `CHK(d[15:0], `TLR_EOL)
    bus(0, `TLR_OFF_STAT, 0); `CHK(d[2:0], 3'b110)
    $display("test end marker done");
    close_out();
  end
endmodule
